// ===== core/spi_eeprom_cmd_protect.sv
`timescale 1ns/1ns
module spi_eeprom_cmd_protect #(
    parameter int WC_CYCLES  = eeprom_pkg::WC_CYCLES,
    parameter int PUP_CYCLES = eeprom_pkg::PUP_CYCLES
) (
    input  wire logic                   mclk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   sck_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   si_i,
    input  wire logic                   hold_n_i,
    input  wire logic                   wp_n_i,
    input  wire logic [7:0]             mem_rd_data_i,
    output logic                        so_o,
    output logic                        so_oe_o,
    output logic [13:0]                 mem_rd_addr_o,
    output logic                        mem_rd_id_o,
    output eeprom_pkg::page_ld_t        page_ld_o,
    output eeprom_pkg::prog_req_t       prog_req_o,
    output logic [7:0]                  status_o,
    output logic                        standby_o
);

    localparam logic [20:0] WC_LAST  = 21'(WC_CYCLES - 1);
    localparam logic [20:0] PUP_LAST = 21'(PUP_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////
    // Link side: frame decoding on the serial clock

    logic [1:0]                 rst_sync_ff;
    logic                       rst_n;
    eeprom_pkg::phase_t         phase_ff;
    logic [2:0]                 bit_ff;
    logic [6:0]                 shift_ff;
    logic [7:0]                 op_ff;
    logic [7:0]                 addr_hi_ff;
    logic [13:0]                rd_addr_ff;
    logic [13:0]                nxt_rd_addr;
    logic [5:0]                 wr_off_ff;
    logic [7:0]                 in_byte;
    eeprom_pkg::page_ld_t       ld_ff;
    eeprom_pkg::frame_rec_t     rec_ff;
    logic [7:0]                 so_sh_ff;
    logic                       so_act_ff;
    logic [7:0]                 shadow_ff;
    logic                       rd_stat;
    logic                       rd_mem;

    assign in_byte = {shift_ff, si_i};

    // Id page reads wrap within the page, array reads over the top
    always_comb begin
        nxt_rd_addr = rd_addr_ff + 14'h0001;
        if (shadow_ff[eeprom_pkg::SR_ID_SEL]) begin
            nxt_rd_addr = {rd_addr_ff[13:6], rd_addr_ff[5:0] + 6'h01};
        end
    end

    // Select high clears the frame; no edge is needed after it
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            phase_ff   <= eeprom_pkg::PH_OP;
            bit_ff     <= 3'h0;
            shift_ff   <= 7'h00;
            op_ff      <= eeprom_pkg::OP_NONE;
            addr_hi_ff <= 8'h00;
            rd_addr_ff <= 14'h0000;
            wr_off_ff  <= 6'h00;
            ld_ff      <= '0;
        end else if (hold_n_i) begin
            shift_ff    <= in_byte[6:0];
            bit_ff      <= bit_ff + 3'h1;
            ld_ff.valid <= 1'b0;
            if (bit_ff == 3'h7) begin
                case (phase_ff)
                    eeprom_pkg::PH_OP: begin
                        op_ff    <= in_byte;
                        phase_ff <= eeprom_pkg::PH_ADDR_HI;
                    end
                    eeprom_pkg::PH_ADDR_HI: begin
                        addr_hi_ff <= in_byte;
                        phase_ff   <= eeprom_pkg::PH_ADDR_LO;
                    end
                    eeprom_pkg::PH_ADDR_LO: begin
                        rd_addr_ff <= {addr_hi_ff[5:0], in_byte};
                        wr_off_ff  <= in_byte[5:0];
                        phase_ff   <= eeprom_pkg::PH_DATA;
                    end
                    eeprom_pkg::PH_DATA: begin
                        if (op_ff == eeprom_pkg::OP_WR_MEM) begin
                            ld_ff.valid  <= 1'b1;
                            ld_ff.offset <= wr_off_ff;
                            ld_ff.data   <= in_byte;
                            wr_off_ff    <= wr_off_ff + 6'h01;
                        end
                        rd_addr_ff <= nxt_rd_addr;
                    end
                    default: phase_ff <= eeprom_pkg::PH_OP;
                endcase
            end
        end
    end

    // Frame record outlives the frame; the system side reads it
    // only after select rises, when the serial clock is still
    always_ff @(posedge sck_i or negedge rst_n) begin
        if (!rst_n) begin
            rec_ff <= '0;
        end else if (hold_n_i && !cs_n_i) begin
            rec_ff.aligned <= (bit_ff == 3'h7);
            if (phase_ff == eeprom_pkg::PH_OP && bit_ff == 3'h0) begin
                rec_ff.op        <= eeprom_pkg::OP_NONE;
                rec_ff.has_data  <= 1'b0;
                rec_ff.addr_done <= 1'b0;
            end
            if (bit_ff == 3'h7) begin
                case (phase_ff)
                    eeprom_pkg::PH_OP: rec_ff.op <= in_byte;
                    eeprom_pkg::PH_ADDR_HI: begin
                        if (op_ff == eeprom_pkg::OP_WR_STATUS) begin
                            rec_ff.sdata    <= in_byte;
                            rec_ff.has_data <= 1'b1;
                        end
                    end
                    eeprom_pkg::PH_ADDR_LO: begin
                        rec_ff.addr      <= {addr_hi_ff[5:0], in_byte};
                        rec_ff.addr_done <= 1'b1;
                    end
                    eeprom_pkg::PH_DATA: begin
                        if (op_ff == eeprom_pkg::OP_WR_MEM) begin
                            rec_ff.has_data <= 1'b1;
                        end
                    end
                    default: rec_ff.has_data <= 1'b0;
                endcase
            end
        end
    end

    assign rd_stat = (op_ff == eeprom_pkg::OP_RD_STATUS);
    // Memory reads are dropped while an internal write runs
    assign rd_mem  = (op_ff == eeprom_pkg::OP_RD_MEM)
                   && (phase_ff == eeprom_pkg::PH_DATA)
                   && !shadow_ff[0];

    // Output byte is loaded on the falling edge after a byte ends
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_sh_ff  <= 8'h00;
            so_act_ff <= 1'b0;
        end else if (hold_n_i) begin
            if (bit_ff == 3'h0 && rd_stat
                && phase_ff != eeprom_pkg::PH_OP) begin
                so_sh_ff  <= shadow_ff;
                so_act_ff <= 1'b1;
            end else if (bit_ff == 3'h0 && rd_mem) begin
                so_sh_ff  <= mem_rd_data_i;
                so_act_ff <= 1'b1;
            end else begin
                so_sh_ff <= {so_sh_ff[6:0], 1'b0};
            end
        end
    end

    assign so_o          = so_sh_ff[7];
    assign so_oe_o       = so_act_ff && hold_n_i && !cs_n_i;
    assign mem_rd_addr_o = rd_addr_ff;
    assign mem_rd_id_o   = shadow_ff[eeprom_pkg::SR_ID_SEL];
    assign page_ld_o     = ld_ff;

    ////////////////////////////////////////////////////////////////////
    // System side: reset, synchronisers, power-up

    logic [2:0]         cs_sync_ff;
    logic [1:0]         wp_sync_ff;
    logic               frame_end;
    logic [20:0]        pup_cnt_ff;
    logic               pup_done_ff;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_ff <= 3'h7;
            wp_sync_ff <= 2'h3;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], cs_n_i};
            wp_sync_ff <= {wp_sync_ff[0], wp_n_i};
        end
    end
    assign frame_end = cs_sync_ff[1] && !cs_sync_ff[2];

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pup_cnt_ff  <= 21'h000000;
            pup_done_ff <= 1'b0;
        end else if (!pup_done_ff) begin
            pup_cnt_ff  <= pup_cnt_ff + 21'h000001;
            pup_done_ff <= (pup_cnt_ff == PUP_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command execution at the close of a frame

    logic               prot_en_ff;
    logic               id_sel_ff;
    logic               id_lock_ff;
    logic [1:0]         bp_ff;
    logic               latch_ff;
    logic               busy_ff;
    logic [20:0]        wc_cnt_ff;
    logic               wc_done;
    logic               hw_lock;
    logic               both_id;
    logic [13:0]        tgt_addr;
    logic               tgt_prot;
    logic               accept;
    logic               do_set;
    logic               do_clr;
    logic               do_write_status_op;
    logic               do_write;
    logic               do_read;
    logic [7:0]         status;

    function automatic logic blk_prot(input logic [1:0]  bp,
                                      input logic [13:0] a);
        case (bp)
            eeprom_pkg::BP_NONE:    blk_prot = 1'b0;
            eeprom_pkg::BP_QUARTER: blk_prot = (a[13:12] == 2'h3);
            eeprom_pkg::BP_HALF:    blk_prot = a[13];
            eeprom_pkg::BP_FULL:    blk_prot = 1'b1;
            default:                blk_prot = 1'b1;
        endcase
    endfunction

    assign hw_lock  = prot_en_ff && !wp_sync_ff[1];
    assign both_id  = rec_ff.sdata[eeprom_pkg::SR_ID_SEL]
                   && rec_ff.sdata[eeprom_pkg::SR_ID_LOCK];
    assign tgt_addr = id_sel_ff ? {8'h00, rec_ff.addr[5:0]}
                                : rec_ff.addr;
    assign tgt_prot = blk_prot(bp_ff, tgt_addr)
                   || (id_sel_ff && id_lock_ff);
    assign accept   = frame_end && pup_done_ff && !busy_ff;
    assign do_set   = accept && rec_ff.aligned
                   && rec_ff.op == eeprom_pkg::OP_SET_LATCH;
    assign do_clr   = accept && rec_ff.aligned
                   && rec_ff.op == eeprom_pkg::OP_CLR_LATCH;
    assign do_write_status_op  = accept && rec_ff.aligned && rec_ff.has_data
                   && rec_ff.op == eeprom_pkg::OP_WR_STATUS
                   && latch_ff && !hw_lock;
    assign do_write = accept && rec_ff.aligned && rec_ff.has_data
                   && rec_ff.op == eeprom_pkg::OP_WR_MEM
                   && latch_ff && !tgt_prot;
    assign do_read  = accept && rec_ff.addr_done
                   && rec_ff.op == eeprom_pkg::OP_RD_MEM;
    assign wc_done  = busy_ff && (wc_cnt_ff == WC_LAST);

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            latch_ff <= 1'b0;
        end else if (do_set) begin
            latch_ff <= 1'b1;
        end else if (do_clr || wc_done) begin
            latch_ff <= 1'b0;
        end
    end

    // Busy is hardware-owned; status write data never reaches it, though the write starts a cycle
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff   <= 1'b0;
            wc_cnt_ff <= 21'h000000;
        end else if (do_write_status_op || do_write) begin
            busy_ff   <= 1'b1;
            wc_cnt_ff <= 21'h000000;
        end else if (busy_ff) begin
            busy_ff   <= !wc_done;
            wc_cnt_ff <= wc_cnt_ff + 21'h000001;
        end
    end

    // Kept in flops; retention across power loss lives elsewhere
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            prot_en_ff <= 1'b0;
            bp_ff      <= eeprom_pkg::BP_NONE;
            id_lock_ff <= 1'b0;
        end else if (do_write_status_op) begin
            prot_en_ff <= rec_ff.sdata[eeprom_pkg::SR_PROT_EN];
            bp_ff      <= rec_ff.sdata[eeprom_pkg::SR_BP_HI:
                                       eeprom_pkg::SR_BP_LO];
            if (!both_id && rec_ff.sdata[eeprom_pkg::SR_ID_LOCK]) begin
                id_lock_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            id_sel_ff <= 1'b0;
        end else if (do_write_status_op && !both_id) begin
            id_sel_ff <= rec_ff.sdata[eeprom_pkg::SR_ID_SEL];
        end else if (do_write || do_read) begin
            id_sel_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            prog_req_o <= '0;
        end else begin
            prog_req_o.valid   <= do_write;
            prog_req_o.id_page <= id_sel_ff;
            prog_req_o.page    <= rec_ff.addr[13:6];
        end
    end

    assign status = {prot_en_ff, id_sel_ff, 1'b0, id_lock_ff,
                     bp_ff, latch_ff, busy_ff};

    // Shadow frozen during a frame so the link sees a stable word
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            shadow_ff <= 8'h00;
            status_o  <= 8'h00;
            standby_o <= 1'b0;
        end else begin
            status_o  <= status;
            standby_o <= cs_sync_ff[2] && !busy_ff;
            if (cs_sync_ff[2]) begin
                shadow_ff <= status;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    property p_oe_off;
        @(posedge mclk_i) disable iff (!rst_n)
        cs_n_i |-> !so_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("output driven while deselected");

    property p_set;
        @(posedge mclk_i) disable iff (!rst_n)
        do_set |=> latch_ff;
    endproperty
    a_set: assert property (p_set)
        else $error("set opcode left latch clear");

    property p_latch_clr;
        @(posedge mclk_i) disable iff (!rst_n)
        $fell(busy_ff) |-> !latch_ff && !$past(do_set);
    endproperty
    a_latch_clr: assert property (p_latch_clr)
        else $error("latch survived write completion");

    property p_prog_latch;
        @(posedge mclk_i) disable iff (!rst_n)
        prog_req_o.valid |-> $past(latch_ff) && busy_ff;
    endproperty
    a_prog_latch: assert property (p_prog_latch)
        else $error("program started without latch");

    property p_wc_bound;
        @(posedge mclk_i) disable iff (!rst_n)
        $fell(busy_ff) |-> $past(wc_cnt_ff) == WC_LAST;
    endproperty
    a_wc_bound: assert property (p_wc_bound)
        else $error("write cycle length wrong");

    property p_both_id;
        @(posedge mclk_i) disable iff (!rst_n)
        do_write_status_op && both_id |=> $stable(id_sel_ff) && $stable(id_lock_ff);
    endproperty
    a_both_id: assert property (p_both_id)
        else $error("id bits changed on joint set");

    property p_hw_lock;
        @(posedge mclk_i) disable iff (!rst_n)
        frame_end && hw_lock |=> $stable(bp_ff) && $stable(prot_en_ff);
    endproperty
    a_hw_lock: assert property (p_hw_lock)
        else $error("status written under pin lock");

    // A write finishing on the same edge legally clears the latch
    property p_busy_ign;
        @(posedge mclk_i) disable iff (!rst_n)
        busy_ff && frame_end && !wc_done
            |=> !prog_req_o.valid && $stable(latch_ff);
    endproperty
    a_busy_ign: assert property (p_busy_ign)
        else $error("command acted on while busy");

    property p_id_clear;
        @(posedge mclk_i) disable iff (!rst_n)
        prog_req_o.valid |-> !id_sel_ff;
    endproperty
    a_id_clear: assert property (p_id_clear)
        else $error("id select kept after write");

    property p_prot;
        @(posedge mclk_i) disable iff (!rst_n)
        do_write |-> !blk_prot(bp_ff, tgt_addr) ##1 prog_req_o.valid;
    endproperty
    a_prot: assert property (p_prot)
        else $error("protected block accepted write");

endmodule

// ===== core/eeprom_pkg.sv
package eeprom_pkg;

    ////////////////////////////////////////////////////////////////////
    // Opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_RD_MEM    = 8'h03;
    localparam logic [7:0] OP_WR_MEM    = 8'h02;
    localparam logic [7:0] OP_NONE      = 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Status register bit positions
    localparam int SR_PROT_EN = 7;
    localparam int SR_ID_SEL  = 6;
    localparam int SR_ID_LOCK = 4;
    localparam int SR_BP_HI   = 3;
    localparam int SR_BP_LO   = 2;

    ////////////////////////////////////////////////////////////////////
    // Block protect codes and array geometry
    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;
    localparam logic [1:0] BP_FULL    = 2'h3;
    localparam int ADDR_W = 14;
    localparam int OFS_W  = 6;
    localparam int PAGE_W = ADDR_W - OFS_W;

    ////////////////////////////////////////////////////////////////////
    // Timing at the system clock rate
    localparam int CLK_MHZ    = 250;
    localparam int T_WC_US    = 5000;
    localparam int T_PUP_US   = 100;
    localparam int WC_CYCLES  = T_WC_US * CLK_MHZ;
    localparam int PUP_CYCLES = T_PUP_US * CLK_MHZ;
    localparam int CNT_W      = 21;

    ////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        PH_OP, PH_ADDR_HI, PH_ADDR_LO, PH_DATA
    } phase_t;

    typedef struct packed {
        logic [7:0]        op;
        logic [7:0]        sdata;
        logic [ADDR_W-1:0] addr;
        logic              addr_done;
        logic              has_data;
        logic              aligned;
    } frame_rec_t;

    typedef struct packed {
        logic             valid;
        logic [OFS_W-1:0] offset;
        logic [7:0]       data;
    } page_ld_t;

    typedef struct packed {
        logic              valid;
        logic              id_page;
        logic [PAGE_W-1:0] page;
    } prog_req_t;

endpackage

// ===== verification/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    output logic      hold_n_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    logic [63:0] rx_bits;
    logic        cpol;
    int          hold_bit;

    initial begin
        sck_o    = 1'b0;
        cs_n_o   = 1'b1;
        si_o     = 1'b0;
        hold_n_o = 1'b1;
        rx_bits  = 64'h0;
        cpol     = 1'b0;
        hold_bit = -1;
    end

    ////////////////////////////////////////////////////////////////////
    // Mode (0,0) idles the clock low, mode (1,1) high; data set while low
    task automatic frame(input logic [63:0] tx, input int nbits);
        rx_bits = 64'h0;
        sck_o   = cpol;
        #7 cs_n_o = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            if (cpol) begin
                #40 sck_o = 1'b0;
            end
            si_o = tx[i];
            // Pause away from the falling edge; stray clocks must be ignored
            if (i == hold_bit) begin
                #20 hold_n_o = 1'b0;
                #40 sck_o = 1'b1;
                #40 sck_o = 1'b0;
                #40 hold_n_o = 1'b1;
            end
            #40 sck_o = 1'b1;
            // Undriven output must not pass for data
            rx_bits = {rx_bits[62:0], so_oe_i ? so_i : 1'bx};
            if (!cpol) begin
                #40 sck_o = 1'b0;
            end
        end
        si_o = ~si_o;
        #40 cs_n_o = 1'b1;
        #100;
    endtask
endmodule

// ===== verification/spi_eeprom_cmd_protect_bench.sv
`timescale 1ns/1ns
module spi_eeprom_cmd_protect_bench;
    localparam int WC = 200;
    logic                  mclk = 1'b0;
    logic                  nrst, wp_n, sck, cs_n, si, hold_n;
    logic                  so, so_oe, rd_id, standby;
    logic [13:0]           rd_addr;
    logic [7:0]            status, d, ld_data;
    eeprom_pkg::page_ld_t  page_ld;
    eeprom_pkg::prog_req_t prog_req, last_prog;
    int                    failures = 0, checked = 0, progs = 0, p;
    logic [15:0]           exp_q[$];
    logic [15:0]           seen, exp;
    event                  got;

    always #2 mclk = ~mclk;

    spi_eeprom_cmd_protect #(.WC_CYCLES(WC), .PUP_CYCLES(20))
    spi_eeprom_cmd_protect_i (
        .mclk_i(mclk), .nrst_i(nrst), .sck_i(sck), .cs_n_i(cs_n),
        .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n),
        .mem_rd_data_i(rd_addr[7:0] ^ 8'h5a), .so_o(so), .so_oe_o(so_oe),
        .mem_rd_addr_o(rd_addr), .mem_rd_id_o(rd_id), .page_ld_o(page_ld),
        .prog_req_o(prog_req), .status_o(status), .standby_o(standby));

    spi_host_model spi_host_model_i (
        .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
        .so_i(so), .so_oe_i(so_oe));

    always @(posedge mclk) begin
        if (prog_req.valid === 1'b1) begin
            progs++;
            last_prog <= prog_req;
        end
        if (page_ld.valid === 1'b1) ld_data <= page_ld.data;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [15:0] e,
                       input logic [15:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic op(input logic [63:0] tx, input int nbits);
        spi_host_model_i.frame(tx, nbits);
    endtask

    task automatic rx(input logic [63:0] tx, input int n, input logic [15:0] e);
        exp_q.push_back(e);
        spi_host_model_i.frame(tx, n);
        seen = spi_host_model_i.rx_bits[15:0];
        ->got;
        // Let the watcher take the note before anything else runs
        @(posedge mclk);
    endtask

    // Status byte repeats, so two copies land in the low bits
    task automatic rs(input logic [7:0] e);
        rx(64'h05_0000, 24, {e, e});
    endtask

    // Self-timed cycle length is fixed by the parameter
    task automatic wait_wc;
        repeat (WC + 20) @(posedge mclk);
    endtask

    initial forever begin
        @got;
        exp = exp_q.pop_front();
        cmp("so_o", exp, seen);
    end

    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(85449));
        nrst = 1'b0;
        wp_n = 1'b1;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        repeat (40) @(posedge mclk);
        rs(8'h00);
        op(64'hff, 8); rs(8'h00);
        op(64'h06, 8); rs(8'h02);
        op(64'h04, 8); rs(8'h00);
        op(64'h018c, 16); rs(8'h00);
        $display("test opcodes done");
        op(64'h06, 8); op(64'h018c, 16); rs(8'h8f);
        wait_wc; rs(8'h8c);
        @(posedge mclk) wp_n <= 1'b0;
        op(64'h06, 8); op(64'h0100, 16); wait_wc; rs(8'h8e);
        @(posedge mclk) wp_n <= 1'b1;
        op(64'h0104, 16); wait_wc; rs(8'h04);
        op(64'h06, 8); op(64'h0154, 16); wait_wc; rs(8'h04);
        $display("test protect done");
        d = 8'($urandom());
        p = progs;
        op(64'h06, 8); op({8'h02, 16'h3000, d}, 32); rs(8'h06);
        cmp("prog_req", 16'(p), 16'(progs));
        op({8'h02, 16'h0000, d}, 32); wait_wc; rs(8'h04);
        cmp("prog_req", 16'(p + 1), 16'(progs));
        cmp("page_ld", {8'h00, d}, {8'h00, ld_data});
        rx({8'h03, 16'h0010, 16'h0}, 40, 16'h4a4b);
        op(64'h06, 8);
        op({8'h02, 16'h0000, d, 4'h0}, 36);
        rs(8'h06);
        cmp("prog_req", 16'(p + 1), 16'(progs));
        $display("test memory done");
        // Id page: select, write, lock, refused write, wrapping read
        op(64'h06, 8);
        op(64'h0144, 16);
        wait_wc;
        rs(8'h44);
        cmp("status_o", 16'h0044, {8'h00, status});
        cmp("rd_id", 16'h0001, {15'h0, rd_id});
        op(64'h06, 8);
        op({8'h02, 16'h0003, d}, 32);
        wait_wc;
        rs(8'h04);
        cmp("prog_id", 16'h0001, {15'h0, last_prog.id_page});
        op(64'h06, 8);
        op(64'h0114, 16);
        wait_wc;
        op(64'h06, 8);
        op(64'h0144, 16);
        wait_wc;
        rs(8'h54);
        op(64'h06, 8);
        op({8'h02, 16'h0003, d}, 32);
        rs(8'h56);
        cmp("prog_req", 16'(p + 2), 16'(progs));
        rx({8'h03, 16'h003f, 16'h0}, 40, 16'h655a);
        rs(8'h16);
        cmp("rd_id", 16'h0000, {15'h0, rd_id});
        $display("test id page done");
        spi_host_model_i.cpol = 1'b1;
        spi_host_model_i.hold_bit = 10;
        rx({8'h03, 16'h0020, 16'h0}, 40, 16'h7a7b);
        rs(8'h16);
        cmp("standby", 16'h0001, {15'h0, standby});
        cmp("so_oe", 16'h0000, {15'h0, so_oe});
        $display("test mode and hold done");
        final_report();
    end
endmodule
